// >>> lcd_mode_defs.svh
// register offsets, field positions and reset values of the panel mode bank
`ifndef LCD_MODE_DEFS_SVH
`define LCD_MODE_DEFS_SVH
`define REG_BASE_ADDR     17'h1ffe0
`define REG_BASE_TOP      12
`define ADDR_CHIP_ID      17'h1ffe0
`define ADDR_PANEL_MODE   17'h1ffe1
`define MODE_RESET        8'h00
`define BIT_CLASS         7
`define BIT_DUAL          6
`define BIT_COLOR         5
`define BIT_LINE_POL      4
`define BIT_FRAME_POL     3
`define BIT_SHIFT_MASK    2
`define BIT_WIDTH_HI      1
`define BIT_WIDTH_LO      0
`define ID_PRODUCT_W      6
`define ID_REVISION_W     2
`endif

// >>> lcd_mode_pkg.sv
// types shared by the panel mode bank
package lcd_mode_pkg;
  typedef enum logic [2:0] {
    FMT_MONO4, FMT_MONO8, FMT_MONO_DUAL8, FMT_COLOR4, FMT_COLOR8_F1,
    FMT_COLOR8_F2, FMT_COLOR_DUAL8, FMT_TFT9
  } panelFormat_t;
  typedef enum logic {
    BUS_IDLE, BUS_HOLD
  } busState_t;
endpackage : lcd_mode_pkg

// >>> panel_format_decode.sv
// decodes the mode register into a panel data format
`timescale 1ns/1ns
`include "lcd_mode_defs.svh"
module panel_format_decode
  import lcd_mode_pkg::*;
(
  input  wire logic [7:0] modeReg,
  output panelFormat_t    format,
  output logic            tft12
);
  logic       isTft;
  logic       isDual;
  logic       isColor;
  logic [1:0] width;
  always_comb begin
    isTft   = modeReg[`BIT_CLASS];
    isDual  = modeReg[`BIT_DUAL];
    isColor = modeReg[`BIT_COLOR];
    width   = {modeReg[`BIT_WIDTH_HI], modeReg[`BIT_WIDTH_LO]};
    tft12   = isTft & width[0];
    format  = FMT_MONO4;
    if (isTft) begin
      format = FMT_TFT9; // dual and colour ignored
    end else if (!isColor) begin
      // reserved width codes are decoded from width bit 0 alone
      if (isDual)
        format = FMT_MONO_DUAL8;
      else if (width[0])
        format = FMT_MONO8;
      else
        format = FMT_MONO4;
    end else begin
      if (isDual)
        format = FMT_COLOR_DUAL8;
      else begin
        case (width)
          2'h0:    format = FMT_COLOR4;
          2'h1:    format = FMT_COLOR8_F1;
          2'h3:    format = FMT_COLOR8_F2;
          default: format = FMT_COLOR4;
        endcase
      end
    end
  end
endmodule : panel_format_decode

// >>> lcd_panel_mode_registers.sv
// identification and panel mode registers with host access and panel controls
//
// Contract
// - every mode register bit clears to zero at reset; the identification register always reads its fixed code.
// - the identification register is read-only with product code in 7:2 and revision in 1:0.
// - mode bit 7 picks passive (0) or active-matrix (1) panels.
// - in active-matrix mode the dual and colour bits are ignored.
// - mode bit 6 picks single (0) or dual (1) panel drive.
// - mode bit 4 sets line pulse polarity in active-matrix mode only, 1 meaning active high.
// - mode bit 3 sets frame pulse polarity in active-matrix mode only, 1 meaning active high.
// - the shift pulse is suppressed in non-display time for colour passive panels or when bit 2 is set.
// - monochrome passive width codes select 4-bit, 8-bit or dual 8-bit interfaces.
// - colour passive width codes select 4-bit, 8-bit formats one and two, or dual 8-bit.
// - in active-matrix mode width bit 0 picks a 9-bit or 12-bit panel.
// - registers answer only with chip select low and address 1ffe0 to 1ffff.
`timescale 1ns/1ns
`include "lcd_mode_defs.svh"
module lcd_panel_mode_registers
  import lcd_mode_pkg::*;
#(
  parameter logic [5:0] PRODUCT_CODE  = 6'h15, // arbitrary
  parameter logic [1:0] REVISION_CODE = 2'h1   // arbitrary
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        chipSelect_n,
  input  wire logic        readStrobe_n,
  input  wire logic        writeStrobe_n,
  input  wire logic [16:0] host_address_bus,
  input  wire logic [7:0]  writeData,
  output logic      [7:0]  readData,
  output logic             readDataEnable,
  input  wire logic        rawLinePulse,
  input  wire logic        rawFramePulse,
  input  wire logic        rawShiftPulse,
  input  wire logic        nonDisplay,
  output logic             line_pulse,
  output logic             frame_pulse,
  output logic             shift_pulse,
  output logic             panel_class_select,
  output logic             dualDrive,
  output logic             colorPanel,
  output logic             shift_pulse_mask,
  output panelFormat_t     panelFormat,
  output logic             tft12
);
  // two-flop synchronisers for the asynchronous host pins
  logic [19:0] pinMeta;
  logic [19:0] pinSync;
  logic [19:0] next_pinMeta;
  logic [19:0] next_pinSync;
  // data bus gets its own two flops so it lines up with the strobes
  logic [7:0]  dataMeta;
  logic [7:0]  dataSync;
  logic [7:0]  next_dataMeta;
  logic [7:0]  next_dataSync;
  logic [7:0]  modeReg;
  logic [7:0]  next_modeReg;
  logic [7:0]  readData_r;
  logic [7:0]  next_readData;
  logic        readEn_r;
  logic        next_readEn;
  busState_t   state;
  busState_t   next_state;
  logic        csSel;
  logic        rdSel;
  logic        wrSel;
  logic [16:0] addrSync;
  logic        inRange;
  logic [7:0]  idValue;
  logic        maskActive;
  // registers occupy the top 32 bytes of the address space
  localparam logic [16:0] REG_BASE = `REG_BASE_ADDR;

  always_comb begin
    next_pinMeta = {chipSelect_n, readStrobe_n, writeStrobe_n, host_address_bus};
    next_pinSync = pinMeta;
    next_dataMeta = writeData;
    next_dataSync = dataMeta;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta <= 20'hfffff;
      pinSync <= 20'hfffff;
      dataMeta <= 8'h00;
      dataSync <= 8'h00;
    end else begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
      dataMeta <= next_dataMeta;
      dataSync <= next_dataSync;
    end
  end

  always_comb begin
    csSel    = ~pinSync[19];
    rdSel    = ~pinSync[18];
    wrSel    = ~pinSync[17];
    addrSync = pinSync[16:0];
    inRange  = csSel && (addrSync[16:5] == REG_BASE[16:5]);
    idValue  = {PRODUCT_CODE, REVISION_CODE};
  end

  // one access per strobe assertion; hold until strobes release
  always_comb begin
    next_state    = state;
    next_modeReg  = modeReg;
    next_readData = readData_r;
    next_readEn   = readEn_r;
    case (state)
      BUS_IDLE: begin
        next_readEn = 1'b0;
        if (inRange && wrSel) begin
          if (addrSync == `ADDR_PANEL_MODE)
            next_modeReg = dataSync;
          next_state = BUS_HOLD;
        end else if (inRange && rdSel) begin
          if (addrSync == `ADDR_CHIP_ID)
            next_readData = idValue;
          else if (addrSync == `ADDR_PANEL_MODE)
            next_readData = modeReg;
          else
            next_readData = 8'h00;
          next_readEn = 1'b1;
          next_state  = BUS_HOLD;
        end
      end
      BUS_HOLD: begin
        if (!(csSel && (rdSel || wrSel))) begin
          next_state  = BUS_IDLE;
          next_readEn = 1'b0;
        end
      end
      default: next_state = BUS_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= BUS_IDLE;
      modeReg    <= `MODE_RESET;
      readData_r <= 8'h00;
      readEn_r   <= 1'b0;
    end else begin
      state      <= next_state;
      modeReg    <= next_modeReg;
      readData_r <= next_readData;
      readEn_r   <= next_readEn;
    end
  end

  panel_format_decode u_decode (
    .modeReg (modeReg),
    .format  (panelFormat),
    .tft12   (tft12)
  );

  always_comb begin
    readData           = readData_r;
    readDataEnable     = readEn_r;
    panel_class_select = modeReg[`BIT_CLASS];
    dualDrive          = ~modeReg[`BIT_CLASS] & modeReg[`BIT_DUAL];
    colorPanel         = ~modeReg[`BIT_CLASS] & modeReg[`BIT_COLOR];
    shift_pulse_mask   = modeReg[`BIT_SHIFT_MASK];
    maskActive         = colorPanel | modeReg[`BIT_SHIFT_MASK];
    // raw pulses are active high; active-matrix low polarity inverts
    line_pulse  = panel_class_select ? (rawLinePulse ~^ modeReg[`BIT_LINE_POL]) : rawLinePulse;
    frame_pulse = panel_class_select ? (rawFramePulse ~^ modeReg[`BIT_FRAME_POL]) : rawFramePulse;
    shift_pulse = rawShiftPulse & ~(maskActive & nonDisplay);
  end

  id_readonly_a: assert property (@(posedge clk) disable iff (!rst_n)
    readEn_r && $rose(readEn_r) && $past(addrSync) == `ADDR_CHIP_ID |-> readData == {PRODUCT_CODE, REVISION_CODE})
    else $error("id read wrong");
  ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == BUS_IDLE && inRange && wrSel && addrSync != `ADDR_PANEL_MODE) |=> $stable(modeReg))
    else $error("read-only register written");
  mode_reset_a: assert property (@(posedge clk) !rst_n |=> modeReg == `MODE_RESET)
    else $error("mode not cleared");
  out_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == BUS_IDLE && !inRange) |=> $stable(modeReg))
    else $error("write outside range");
  no_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == BUS_IDLE && !inRange) |=> !readEn_r)
    else $error("answer outside range");
  mode_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == BUS_IDLE && inRange && wrSel && addrSync == `ADDR_PANEL_MODE) |=> modeReg == $past(dataSync))
    else $error("mode write lost");
  tft_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    panel_class_select |-> !dualDrive && !colorPanel)
    else $error("tft not ignoring");
  passive_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    !panel_class_select |-> line_pulse == rawLinePulse && frame_pulse == rawFramePulse)
    else $error("passive polarity");
  line_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    panel_class_select && !modeReg[`BIT_LINE_POL] |-> line_pulse == !rawLinePulse)
    else $error("line polarity");
  frame_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    panel_class_select && !modeReg[`BIT_FRAME_POL] |-> frame_pulse == !rawFramePulse)
    else $error("frame polarity");
  shift_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    nonDisplay && (modeReg[`BIT_SHIFT_MASK] || (modeReg[`BIT_COLOR] && !modeReg[`BIT_CLASS])) |-> !shift_pulse)
    else $error("shift not masked");
  tft_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    modeReg[`BIT_CLASS] |-> panelFormat == FMT_TFT9 && tft12 == modeReg[`BIT_WIDTH_LO])
    else $error("tft width");
  class_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    panel_class_select == modeReg[`BIT_CLASS])
    else $error("class select");
  mono_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    !modeReg[`BIT_CLASS] && !modeReg[`BIT_DUAL] && !modeReg[`BIT_COLOR]
    && !modeReg[`BIT_WIDTH_HI] && modeReg[`BIT_WIDTH_LO]
    |-> panelFormat == FMT_MONO8)
    else $error("mono width");
  color_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    !modeReg[`BIT_CLASS] && !modeReg[`BIT_DUAL] && modeReg[`BIT_COLOR]
    && modeReg[`BIT_WIDTH_HI] && modeReg[`BIT_WIDTH_LO]
    |-> panelFormat == FMT_COLOR8_F2)
    else $error("color width");
  dual_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !modeReg[`BIT_CLASS] |-> dualDrive == modeReg[`BIT_DUAL])
    else $error("dual drive");
endmodule : lcd_panel_mode_registers

// >>> host_bus_model.sv
// host processor model driving the register bus pins
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic        clk,
  input  wire logic [7:0]  readData,
  input  wire logic        readDataEnable,
  output logic             chipSelect_n,
  output logic             readStrobe_n,
  output logic             writeStrobe_n,
  output logic      [16:0] host_address_bus,
  output logic      [7:0]  writeData
);
  initial begin
    {chipSelect_n, readStrobe_n, writeStrobe_n, host_address_bus, writeData} = {3'b111, 25'h0};
  end

  // one strobe per access, held until answered or the bound runs out
  task automatic access(input logic sel, input logic wr, input logic [16:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(posedge clk);
    {chipSelect_n, writeStrobe_n, readStrobe_n} <= {~sel, ~wr, wr};
    {host_address_bus, writeData} <= {a, d};
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk);
      if (!wr && readDataEnable === 1'b1) begin
        ok = 1'b1;
        q = readData;
      end
    end
    ok = ok | wr;
    @(posedge clk);
    {chipSelect_n, readStrobe_n, writeStrobe_n} <= 3'b111;
    // released lines show the inverse, not a stale value
    {host_address_bus, writeData} <= ~{a, d};
    repeat (4) @(posedge clk);
  endtask : access
endmodule : host_bus_model

// >>> test_lcd_panel_mode_registers.sv
// self-checking bench for the panel mode register bank
`timescale 1ns/1ns
module test_lcd_panel_mode_registers;
  import lcd_mode_pkg::*;
  localparam logic [5:0] PCODE = 6'h2a; // arbitrary
  localparam logic [1:0] RCODE = 2'h2;  // arbitrary
  logic         clk, rst_n, csN, rdN, wrN, rde, rLine, rFrame, rShift, nonDisp;
  logic         lineP, frameP, shiftP, cls, dual, color, mask, t12, ok;
  logic [16:0]  addr;
  logic [7:0]   wd, rd, q;
  panelFormat_t fmt;
  int           numErrors = 0;
  int           cmpCount = 0;

  lcd_panel_mode_registers #(.PRODUCT_CODE(PCODE), .REVISION_CODE(RCODE)) u_dut (
    .clk(clk), .rst_n(rst_n), .chipSelect_n(csN), .readStrobe_n(rdN), .writeStrobe_n(wrN),
    .host_address_bus(addr), .writeData(wd), .readData(rd), .readDataEnable(rde),
    .rawLinePulse(rLine), .rawFramePulse(rFrame), .rawShiftPulse(rShift), .nonDisplay(nonDisp),
    .line_pulse(lineP), .frame_pulse(frameP), .shift_pulse(shiftP), .panel_class_select(cls),
    .dualDrive(dual), .colorPanel(color), .shift_pulse_mask(mask), .panelFormat(fmt), .tft12(t12));
  host_bus_model u_host (.clk(clk), .readData(rd), .readDataEnable(rde), .chipSelect_n(csN),
    .readStrobe_n(rdN), .writeStrobe_n(wrN), .host_address_bus(addr), .writeData(wd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim;
    $display("errors %0d compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic sel, input logic wr, input logic [16:0] a, input logic [7:0] d);
    u_host.access(sel, wr, a, d, q, ok);
  endtask : acc

  task automatic rchk(input logic [16:0] a, input logic [7:0] exp);
    acc(1'b1, 1'b0, a, 8'h00);
    chk({7'h0, ok}, 8'h01);
    if (ok !== 1'b1) end_sim();
    else chk(q, exp);
  endtask : rchk

  task automatic t_reset;
    rchk(17'h1ffe1, 8'h00);
    rchk(17'h1ffe0, {PCODE, RCODE});
    chk({cls, dual, color, mask, t12, fmt}, 8'h00);
    acc(1'b1, 1'b1, 17'h1ffe0, 8'hff);
    rchk(17'h1ffe0, {PCODE, RCODE});
    acc(1'b0, 1'b1, 17'h1ffe1, 8'h55);
    acc(1'b1, 1'b1, 17'h0ffe1, 8'h55);
    rchk(17'h1ffe1, 8'h00);
    acc(1'b1, 1'b0, 17'h1ffc1, 8'h00);
    chk({7'h0, ok}, 8'h00);
    $display("test reset and decode done");
  endtask : t_reset

  task automatic t_formats;
    logic [7:0]   m [9] = '{8'h00, 8'h01, 8'h41, 8'h20, 8'h21, 8'h23, 8'h61, 8'h80, 8'he1};
    panelFormat_t f [9] = '{FMT_MONO4, FMT_MONO8, FMT_MONO_DUAL8, FMT_COLOR4, FMT_COLOR8_F1,
                            FMT_COLOR8_F2, FMT_COLOR_DUAL8, FMT_TFT9, FMT_TFT9};
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 1'b1, 17'h1ffe1, m[i]);
      rchk(17'h1ffe1, m[i]);
      chk({3'h0, t12, cls, fmt}, {3'h0, m[i][7] & m[i][0], m[i][7], f[i]});
      if (!m[i][7]) chk({6'h0, dual, color}, {6'h0, m[i][6:5]});
    end
    $display("test formats done");
  endtask : t_formats

  task automatic t_pulses;
    logic [7:0] m [4] = '{8'h18, 8'h80, 8'h90, 8'h88};
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b1, 17'h1ffe1, m[i]);
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        rLine <= v[0];
        rFrame <= ~v[0];
        @(negedge clk);
        chk({7'h0, lineP}, {7'h0, v[0] ^ (m[i][7] & ~m[i][4])});
        chk({7'h0, frameP}, {7'h0, ~v[0] ^ (m[i][7] & ~m[i][3])});
      end
    end
    $display("test pulse polarity done");
  endtask : t_pulses

  task automatic t_shift;
    logic [7:0] m [5] = '{8'h00, 8'h20, 8'h04, 8'h24, 8'ha0};
    logic       nd [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic       e [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 1'b1, 17'h1ffe1, m[i]);
      @(posedge clk);
      rShift <= 1'b1;
      nonDisp <= nd[i];
      @(negedge clk);
      chk({6'h0, shiftP, mask}, {6'h0, e[i], m[i][2]});
    end
    acc(1'b1, 1'b1, 17'h1ffe1, 8'h24);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(17'h1ffe1, 8'h00);
    $display("test shift mask and reset done");
  endtask : t_shift

  initial begin
    {rst_n, rLine, rFrame, rShift, nonDisp} = 5'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_formats();
    t_pulses();
    t_shift();
    end_sim();
  end
endmodule : test_lcd_panel_mode_registers
